/* rtl/dst_defs.vh */
// Constants, command codes, sense codes and register map for the drive self-test sequencer
`ifndef DST_DEFS_VH
`define DST_DEFS_VH

// ----------------------------------------
// APB register offsets
// ----------------------------------------
`define DST_REG_CMD        12'h000
`define DST_REG_CMD_ARG    12'h004
`define DST_REG_RESP       12'h008
`define DST_REG_STATUS     12'h00c
`define DST_REG_EXT_TIME   12'h010
`define DST_REG_MEDIA      12'h014
`define DST_REG_WORK       12'h018
`define DST_REG_LOG_SEL    12'h01c
`define DST_REG_LOG_DATA   12'h020
`define DST_REG_LOG_COUNT  12'h024

// ----------------------------------------
// Command classes written to the command register
// ----------------------------------------
`define DST_CMD_SEND_DIAG  4'h1
`define DST_CMD_INQUIRY    4'h2
`define DST_CMD_RPT_LUNS   4'h3
`define DST_CMD_REQ_SENSE  4'h4
`define DST_CMD_WBUF_DL    4'h5
`define DST_CMD_FORMAT     4'h6
`define DST_CMD_START_STOP 4'h7
`define DST_CMD_OTHER      4'h8
`define DST_CMD_ABORT_TMF  4'h9
`define DST_CMD_DONE       4'ha

// ----------------------------------------
// Function codes
// ----------------------------------------
`define DST_FC_NONE        3'h0
`define DST_FC_BG_SHORT    3'h1
`define DST_FC_BG_EXT      3'h2
`define DST_FC_ABORT_BG    3'h4
`define DST_FC_FG_SHORT    3'h5
`define DST_FC_FG_EXT      3'h6

// ----------------------------------------
// Status, sense keys and codes
// ----------------------------------------
`define DST_ST_GOOD        2'h0
`define DST_ST_CHECK       2'h1
`define DST_ST_SERVE       2'h2
`define DST_SK_NONE        4'h0
`define DST_SK_NOT_READY   4'h2
`define DST_SK_HW_ERROR    4'h4
`define DST_SK_ABORTED     4'hb
`define DST_ASC_IN_PROG    16'h0409
`define DST_ASC_FAILED     16'h3e03
`define DST_ASC_NONE       16'h0000

// ----------------------------------------
// Log result codes and segment numbers
// ----------------------------------------
`define DST_RES_OK         4'h0
`define DST_RES_ABORT_BG   4'h1
`define DST_RES_ABORT_TMF  4'h2
`define DST_RES_FAIL_SEG   4'h7
`define DST_RES_RUNNING    4'hf
`define DST_SEG_FIRST      4'h1
`define DST_SEG_DIAG       4'h2
`define DST_SEG_FORMAT     4'h4
`define DST_SEG_RAND       4'h6
`define DST_SEG_SEQ        4'h7
`define DST_SEG_LAST       4'h8

// ----------------------------------------
// Work unit codes issued to the drive engine
// ----------------------------------------
`define DST_OP_NONE        4'h0
`define DST_OP_READY       4'h1
`define DST_OP_SPIN        4'h2
`define DST_OP_WRC_HEAD    4'h3
`define DST_OP_SEEK        4'h4
`define DST_OP_SMART       4'h5
`define DST_OP_FMT_CHECK   4'h6
`define DST_OP_HEAD_RW     4'h7
`define DST_OP_RAND_VFY    4'h8
`define DST_OP_SEQ_FIRST   4'h9
`define DST_OP_SEQ_LAST    4'ha
`define DST_OP_SEQ_ALL     4'hb

// ----------------------------------------
// Counts and timing
// ----------------------------------------
`define DST_SEEK_COUNT     16'd256
`define DST_RAND_COUNT     16'd4000
`define DST_EXT_TIME_MAX   16'hffff
`define DST_EXT_MAX_SEC    65
`define DST_SUSPEND_MS     2000
`define DST_CLK_KHZ        125000
`define DST_LOG_DEPTH      20

`endif

/* rtl/dst_log_mem.v */
// Circular results log memory with registered read data
`timescale 1ns/10ps
module dst_log_mem #(
   parameter DEPTH = 20,
   parameter AW = 5,
   parameter DW = 12
) (
   input wire clk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:DEPTH-1];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

/* rtl/dst_seq.v */
// Drive self-test sequencer with APB register access
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "dst_defs.vh"
module dst_seq #(
   parameter EXT_MINUTES_SEC = 16'd120,
   parameter SUSPEND_CYCLES = `DST_SUSPEND_MS * `DST_CLK_KHZ,
   parameter LOG_DEPTH = `DST_LOG_DEPTH,
   parameter HEADS = 4'd8
) (
   input wire clk,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output reg [3:0] work_op,
   output reg [15:0] work_arg,
   output reg work_start,
   input wire work_done,
   input wire work_fail
);
   localparam ST_IDLE = 3'd0;
   localparam ST_LOG_INIT = 3'd1;
   localparam ST_ISSUE = 3'd2;
   localparam ST_WAIT = 3'd3;
   localparam ST_SUSP = 3'd4;
   localparam ST_FINISH = 3'd5;
   localparam [31:0] SUSP_LIM = SUSPEND_CYCLES;

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   reg [2:0] st_q;
   reg fg_q;
   reg ext_q;
   reg dflt_q;
   reg [2:0] fc_q;
   reg [3:0] seg_q;
   reg [3:0] sub_q;
   reg [15:0] cnt_q;
   reg fail_q;
   reg [3:0] res_q;
   reg fmt_corrupt_q;
   reg [15:0] ext_time_q;
   reg [1:0] rsp_st_q;
   reg [3:0] rsp_sk_q;
   reg [15:0] rsp_asc_q;
   reg rsp_valid_q;
   reg [15:0] prog_q;
   reg [31:0] susp_cnt_q;
   reg susp_late_q;
   reg [3:0] cmd_arg_q;
   reg [4:0] log_wptr_q;
   reg [4:0] log_cnt_q;
   reg [4:0] log_sel_q;
   reg [1:0] done_hold_q; // Engine answer {fail, done} caught in a command cycle
   reg log_we;
   reg [11:0] log_wdata;
   wire [11:0] log_rdata;

   wire wr = psel && penable && pwrite;
   wire busy = (st_q != ST_IDLE);
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // Class of a test request by function code
   function is_test_fc;
      input [2:0] fc;
      begin
         is_test_fc = (fc == `DST_FC_BG_SHORT) || (fc == `DST_FC_BG_EXT) ||
            (fc == `DST_FC_FG_SHORT) || (fc == `DST_FC_FG_EXT);
      end
   endfunction

   // Work unit of a segment step; sub counts steps inside a segment
   function [3:0] seg_op;
      input [3:0] seg;
      input [3:0] sub;
      input ext;
      begin
         case (seg)
            `DST_SEG_FIRST: seg_op = `DST_OP_READY;
            `DST_SEG_DIAG: seg_op = (sub == 4'h0) ? `DST_OP_SPIN :
               (sub == 4'h1) ? `DST_OP_WRC_HEAD : `DST_OP_SEEK;
            4'h3: seg_op = `DST_OP_SMART;
            `DST_SEG_FORMAT: seg_op = `DST_OP_FMT_CHECK;
            4'h5: seg_op = `DST_OP_HEAD_RW;
            `DST_SEG_RAND: seg_op = `DST_OP_RAND_VFY;
            `DST_SEG_SEQ: seg_op = ext ? `DST_OP_SEQ_ALL :
               ((sub == 4'h0) ? `DST_OP_SEQ_FIRST : `DST_OP_SEQ_LAST);
            `DST_SEG_LAST: seg_op = `DST_OP_SMART;
            default: seg_op = `DST_OP_NONE;
         endcase
      end
   endfunction

   // Repeats of the current step
   function [15:0] rep_count;
      input [3:0] op;
      begin
         case (op)
            `DST_OP_WRC_HEAD, `DST_OP_HEAD_RW: rep_count = {12'h000, HEADS};
            `DST_OP_SEEK: rep_count = `DST_SEEK_COUNT;
            `DST_OP_RAND_VFY: rep_count = `DST_RAND_COUNT;
            default: rep_count = 16'h0001;
         endcase
      end
   endfunction

   // Last step inside a segment
   function last_sub;
      input [3:0] seg;
      input [3:0] sub;
      input ext;
      begin
         last_sub = (seg == `DST_SEG_DIAG) ? (sub == 4'h2) :
            ((seg == `DST_SEG_SEQ) && !ext) ? (sub == 4'h1) : 1'b1;
      end
   endfunction

   wire [3:0] cur_op = seg_op(seg_q, sub_q, ext_q);
   wire [2:0] new_fc = pwdata[2:0];
   wire new_sel = pwdata[3];

   // ----------------------------------------
   // Command handling and sequencing
   // ----------------------------------------
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         fg_q <= 1'b0;
         ext_q <= 1'b0;
         dflt_q <= 1'b0;
         fc_q <= `DST_FC_NONE;
         seg_q <= 4'h0;
         sub_q <= 4'h0;
         cnt_q <= 16'h0000;
         fail_q <= 1'b0;
         res_q <= `DST_RES_OK;
         fmt_corrupt_q <= 1'b0;
         ext_time_q <= 16'h0000;
         rsp_st_q <= `DST_ST_GOOD;
         rsp_sk_q <= `DST_SK_NONE;
         rsp_asc_q <= `DST_ASC_NONE;
         rsp_valid_q <= 1'b0;
         prog_q <= 16'h0000;
         susp_cnt_q <= 32'h0;
         susp_late_q <= 1'b0;
         cmd_arg_q <= 4'h0;
         work_op <= `DST_OP_NONE;
         work_arg <= 16'h0000;
         work_start <= 1'b0;
         log_wptr_q <= 5'h00;
         log_cnt_q <= 5'h00;
         log_sel_q <= 5'h00;
         done_hold_q <= 2'h0;
         log_we <= 1'b0;
         log_wdata <= 12'h000;
      end else begin
         work_start <= 1'b0;
         log_we <= 1'b0;
         // Expected extended duration, saturating to ffff once EXT_MINUTES_SEC reaches DST_EXT_MAX_SEC
         ext_time_q <= (EXT_MINUTES_SEC >= `DST_EXT_MAX_SEC) ? `DST_EXT_TIME_MAX : EXT_MINUTES_SEC;
         prog_q <= {seg_q, sub_q, 8'h00};
         if (wr && paddr == `DST_REG_MEDIA) begin
            fmt_corrupt_q <= pwdata[0];
         end else if (wr && paddr == `DST_REG_LOG_SEL) begin
            log_sel_q <= pwdata[4:0];
         end else if (wr && paddr == `DST_REG_CMD_ARG) begin
            cmd_arg_q <= pwdata[3:0];
         end
         if (st_q == ST_WAIT && susp_cnt_q != SUSP_LIM) begin
            susp_cnt_q <= susp_cnt_q + 32'h1;
         end
         // Advance the log slot on the same edge that writes the final entry
         if (log_we && st_q == ST_IDLE) begin
            log_wptr_q <= (log_wptr_q == LOG_DEPTH - 1) ? 5'h00 : log_wptr_q + 5'h01;
            if (log_cnt_q != LOG_DEPTH) begin
               log_cnt_q <= log_cnt_q + 5'h01;
            end
         end
         if (wr && paddr == `DST_REG_CMD) begin
            done_hold_q <= (work_done && st_q == ST_WAIT) ? {work_fail, 1'b1} : done_hold_q;
            rsp_valid_q <= 1'b1;
            rsp_st_q <= `DST_ST_GOOD;
            rsp_sk_q <= `DST_SK_NONE;
            rsp_asc_q <= `DST_ASC_NONE;
            if (pwdata[7:4] == `DST_CMD_ABORT_TMF && busy && fg_q) begin
               res_q <= `DST_RES_ABORT_TMF;
               st_q <= ST_FINISH;
               rsp_st_q <= `DST_ST_CHECK;
               rsp_sk_q <= `DST_SK_ABORTED;
            end else if (pwdata[7:4] == `DST_CMD_REQ_SENSE) begin
               if (busy && !fail_q) begin
                  rsp_sk_q <= `DST_SK_NOT_READY;
                  rsp_asc_q <= `DST_ASC_IN_PROG;
               end
            end else if (pwdata[7:4] == `DST_CMD_INQUIRY || pwdata[7:4] == `DST_CMD_RPT_LUNS) begin
               rsp_st_q <= `DST_ST_GOOD;
            end else if (busy && fg_q) begin
               rsp_st_q <= `DST_ST_CHECK;
               rsp_sk_q <= `DST_SK_NOT_READY;
               rsp_asc_q <= `DST_ASC_IN_PROG;
            end else if (busy && !fg_q) begin
               if (pwdata[7:4] == `DST_CMD_SEND_DIAG && (new_sel ||
                     (new_fc != `DST_FC_NONE && new_fc != `DST_FC_ABORT_BG))) begin
                  rsp_st_q <= `DST_ST_CHECK;
                  rsp_sk_q <= `DST_SK_NOT_READY;
                  rsp_asc_q <= `DST_ASC_IN_PROG;
               end else if ((pwdata[7:4] == `DST_CMD_SEND_DIAG && new_fc == `DST_FC_ABORT_BG) ||
                     pwdata[7:4] == `DST_CMD_WBUF_DL || pwdata[7:4] == `DST_CMD_FORMAT ||
                     pwdata[7:4] == `DST_CMD_START_STOP) begin
                  res_q <= `DST_RES_ABORT_BG;
                  st_q <= ST_FINISH;
                  rsp_st_q <= `DST_ST_SERVE;
               end else if (pwdata[7:4] == `DST_CMD_DONE) begin
                  if (st_q == ST_SUSP) begin
                     st_q <= ST_ISSUE;
                  end
               end else if (st_q != ST_SUSP) begin
                  st_q <= ST_SUSP;
                  susp_late_q <= (susp_cnt_q == SUSP_LIM);
                  rsp_st_q <= `DST_ST_SERVE;
               end else begin
                  rsp_st_q <= `DST_ST_SERVE;
               end
            end else if (pwdata[7:4] == `DST_CMD_SEND_DIAG) begin
               if (new_sel) begin
                  dflt_q <= 1'b1;
                  fg_q <= 1'b1;
                  ext_q <= 1'b0;
                  seg_q <= `DST_SEG_DIAG;
                  sub_q <= 4'h0;
                  fail_q <= 1'b0;
                  st_q <= ST_ISSUE;
                  rsp_valid_q <= 1'b0;
               end else if (is_test_fc(new_fc)) begin
                  dflt_q <= 1'b0;
                  fc_q <= new_fc;
                  fg_q <= new_fc[2];
                  ext_q <= new_fc[1];
                  seg_q <= `DST_SEG_FIRST;
                  sub_q <= 4'h0;
                  fail_q <= 1'b0;
                  res_q <= `DST_RES_RUNNING;
                  if (new_fc[2]) begin
                     st_q <= ST_ISSUE;
                     rsp_valid_q <= 1'b0;
                  end else begin
                     st_q <= ST_LOG_INIT;
                  end
               end
            end
         end else begin
            case (st_q)
               ST_LOG_INIT: begin
                  log_we <= 1'b1;
                  log_wdata <= {1'b0, fc_q, `DST_RES_RUNNING, 4'h0};
                  st_q <= ST_ISSUE;
               end
               ST_ISSUE: begin
                  work_op <= cur_op;
                  work_arg <= (cur_op == `DST_OP_SEQ_FIRST) ? 16'd300 :
                     (cur_op == `DST_OP_SEQ_LAST) ? 16'd100 : 16'h0000;
                  cnt_q <= rep_count(cur_op);
                  susp_cnt_q <= 32'h0;
                  done_hold_q <= 2'h0;
                  if (cur_op == `DST_OP_FMT_CHECK && fmt_corrupt_q) begin
                     fail_q <= 1'b1;
                     res_q <= `DST_RES_FAIL_SEG;
                     st_q <= ST_FINISH;
                  end else begin
                     work_start <= 1'b1;
                     st_q <= ST_WAIT;
                  end
               end
               ST_WAIT: begin
                  if (work_done || done_hold_q[0]) begin
                     done_hold_q <= 2'h0;
                     if ((work_done && work_fail) || done_hold_q[1]) begin
                        fail_q <= 1'b1;
                        res_q <= `DST_RES_FAIL_SEG;
                        st_q <= ST_FINISH;
                     end else if (cnt_q != 16'h0001) begin
                        cnt_q <= cnt_q - 16'h0001;
                        work_arg <= work_arg + 16'h0001;
                        work_start <= 1'b1;
                     end else if (!last_sub(seg_q, sub_q, ext_q)) begin
                        sub_q <= sub_q + 4'h1;
                        st_q <= ST_ISSUE;
                     end else if (dflt_q || seg_q == `DST_SEG_LAST) begin
                        res_q <= `DST_RES_OK;
                        st_q <= ST_FINISH;
                     end else begin
                        seg_q <= seg_q + 4'h1;
                        sub_q <= 4'h0;
                        st_q <= ST_ISSUE;
                     end
                  end
               end
               ST_FINISH: begin
                  st_q <= ST_IDLE;
                  work_op <= `DST_OP_NONE;
                  log_we <= !dflt_q;
                  log_wdata <= {1'b0, fc_q, res_q, seg_q};
                  if (fg_q && res_q != `DST_RES_ABORT_TMF) begin
                     rsp_valid_q <= 1'b1;
                     rsp_st_q <= fail_q ? `DST_ST_CHECK : `DST_ST_GOOD;
                     rsp_sk_q <= (fail_q && !dflt_q) ? `DST_SK_HW_ERROR : `DST_SK_NONE;
                     rsp_asc_q <= (fail_q && !dflt_q) ? `DST_ASC_FAILED : `DST_ASC_NONE;
                  end
               end
               default: st_q <= st_q;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Results log storage
   // ----------------------------------------
   dst_log_mem #(
      .DEPTH(LOG_DEPTH),
      .AW(5),
      .DW(12)
   ) u_log (
      .clk(clk),
      .we(log_we),
      .waddr(log_wptr_q),
      .wdata(log_wdata),
      .raddr(log_sel_q),
      .rdata(log_rdata)
   );

   // ----------------------------------------
   // APB read data
   // ----------------------------------------
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == `DST_REG_RESP) begin
            prdata <= {7'h0, rsp_valid_q, rsp_asc_q, rsp_sk_q, 2'h0, rsp_st_q};
         end else if (paddr == `DST_REG_STATUS) begin
            prdata <= {prog_q, 2'h0, susp_late_q, fail_q, seg_q, 1'b0, fg_q, ext_q, dflt_q, 1'b0, st_q};
         end else if (paddr == `DST_REG_EXT_TIME) begin
            prdata <= {16'h0, ext_time_q};
         end else if (paddr == `DST_REG_MEDIA) begin
            prdata <= {31'h0, fmt_corrupt_q};
         end else if (paddr == `DST_REG_WORK) begin
            prdata <= {12'h0, work_op, work_arg};
         end else if (paddr == `DST_REG_LOG_SEL) begin
            prdata <= {27'h0, log_sel_q};
         end else if (paddr == `DST_REG_LOG_DATA) begin
            prdata <= {20'h0, log_rdata};
         end else if (paddr == `DST_REG_LOG_COUNT) begin
            prdata <= {22'h0, log_wptr_q, log_cnt_q};
         end else if (paddr == `DST_REG_CMD_ARG) begin
            prdata <= {28'h0, cmd_arg_q};
         end else begin
            prdata <= 32'h0;
         end
      end
   end
endmodule

/* tb/dst_engine_model.sv */
// Behavioural drive engine that answers work units
`timescale 1ns/10ps
module dst_engine_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic work_start,
   input wire logic [3:0] work_op,
   input wire logic [3:0] fail_op,
   input wire logic [1:0] lat,
   output logic work_done,
   output logic work_fail
);
   logic [2:0] cnt_q;
   logic busy_q;
   logic bad_q;
   // Done comes lat+2 cycles after a start; fail is only high beside done
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         cnt_q <= 3'h0;
         bad_q <= 1'b0;
         work_done <= 1'b0;
         work_fail <= 1'b0;
      end else begin
         work_done <= busy_q && cnt_q == 3'h0;
         work_fail <= busy_q && cnt_q == 3'h0 && bad_q;
         if (work_start) begin
            busy_q <= 1'b1;
            cnt_q <= {1'b0, lat};
            bad_q <= fail_op != 4'h0 && work_op == fail_op;
         end else if (busy_q) begin
            if (cnt_q == 3'h0) busy_q <= 1'b0;
            else cnt_q <= cnt_q - 3'h1;
         end
      end
   end
endmodule

/* tb/dst_seq_bench.sv */
// Self-checking bench for the self-test sequencer
`timescale 1ns/10ps
`include "dst_defs.vh"
module dst_seq_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] fail_op = 4'h0;
   logic [1:0] lat = 2'h0;
   wire [31:0] prdata;
   wire pready, pslverr, work_start, work_done, work_fail;
   wire [3:0] work_op;
   wire [15:0] work_arg;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int i;
   logic [31:0] q;
   always #4 clk = ~clk;
   dst_seq u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .work_op(work_op),
      .work_arg(work_arg), .work_start(work_start), .work_done(work_done), .work_fail(work_fail));
   dst_engine_model u_eng (.clk(clk), .rst_b(rst_b), .work_start(work_start), .work_op(work_op),
      .fail_op(fail_op), .lat(lat), .work_done(work_done), .work_fail(work_fail));
   // ----
   // Bus tasks
   // ----
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
      total_checks++;
      if ((g & m) !== (e & m)) begin
         bad_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, g & m, e & m);
      end
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(q, e, m);
   endtask
   task logchk(input logic [4:0] s, input logic [31:0] e, input logic [31:0] m);
      apb(1'b1, `DST_REG_LOG_SEL, {27'h0, s});
      rdchk(`DST_REG_LOG_DATA, e, m);
   endtask
   task wait_idle;
      int n;
      n = 0;
      apb(1'b0, `DST_REG_STATUS, 32'h0);
      while (q[2:0] !== 3'h0 && n < 40000) begin
         apb(1'b0, `DST_REG_STATUS, 32'h0);
         n++;
      end
   endtask
   task results;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         results();
      end
   end
   // ----
   // Tests
   // ----
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rdchk(`DST_REG_RESP, 32'h0, 32'hffffffff);
      rdchk(`DST_REG_LOG_COUNT, 32'h0, 32'h1f);
      rdchk(`DST_REG_EXT_TIME, 32'hffff, 32'hffff);
      rdchk(12'h100, 32'h0, 32'hffffffff);
      for (i = 0; i < 2; i++) begin
         fail_op <= i ? `DST_OP_SEEK : 4'h0;
         lat <= i ? 2'h0 : 2'h2;
         apb(1'b1, `DST_REG_CMD, 32'h18);
         wait_idle();
         rdchk(`DST_REG_RESP, {31'h0080_0000, i[0]}, 32'h0100_0003);
         rdchk(`DST_REG_LOG_COUNT, 32'h0, 32'h1f);
      end
      fail_op <= 4'h0;
      apb(1'b1, `DST_REG_CMD, 32'h15);
      rdchk(`DST_REG_RESP, 32'h0, 32'h0100_0000);
      apb(1'b1, `DST_REG_CMD, 32'h80);
      rdchk(`DST_REG_RESP, 32'h0004_0921, 32'h00ff_fff3);
      for (i = 2; i < 4; i++) begin
         apb(1'b1, `DST_REG_CMD, {24'h0, i[3:0], 4'h0});
         rdchk(`DST_REG_RESP, 32'h0, 32'h00ff_fff3);
      end
      apb(1'b1, `DST_REG_CMD, 32'h40);
      rdchk(`DST_REG_RESP, 32'h0004_0920, 32'h00ff_fff0);
      wait_idle();
      rdchk(`DST_REG_RESP, 32'h0100_0000, 32'h01ff_fff3);
      logchk(5'd0, 32'h508, 32'h7ff);
      apb(1'b1, `DST_REG_MEDIA, 32'h1);
      apb(1'b1, `DST_REG_CMD, 32'h15);
      wait_idle();
      rdchk(`DST_REG_RESP, 32'h013e_0341, 32'h01ff_fff3);
      logchk(5'd1, 32'h574, 32'h7ff);
      apb(1'b1, `DST_REG_MEDIA, 32'h0);
      apb(1'b1, `DST_REG_CMD, 32'h16);
      apb(1'b1, `DST_REG_CMD, 32'h90);
      rdchk(`DST_REG_RESP, 32'hb1, 32'hf3);
      wait_idle();
      logchk(5'd2, 32'h620, 32'h7f0);
      apb(1'b1, `DST_REG_CMD, 32'h11);
      rdchk(`DST_REG_RESP, 32'h0100_0000, 32'h0100_0003);
      logchk(5'd3, 32'h1f0, 32'h7f0);
      for (i = 0; i < 2; i++) begin
         apb(1'b1, `DST_REG_CMD, i ? 32'h15 : 32'h18);
         rdchk(`DST_REG_RESP, 32'h0004_0921, 32'h00ff_fff3);
      end
      apb(1'b1, `DST_REG_CMD, 32'h80);
      rdchk(`DST_REG_STATUS, 32'h4, 32'h7);
      apb(1'b1, `DST_REG_CMD, 32'ha0);
      rdchk(`DST_REG_STATUS, 32'h2, 32'h6);
      apb(1'b1, `DST_REG_CMD, 32'h14);
      wait_idle();
      logchk(5'd3, 32'h110, 32'h7f0);
      for (i = 0; i < 17; i++) begin
         apb(1'b1, `DST_REG_CMD, 32'h12);
         apb(1'b1, `DST_REG_CMD, 32'h50 + 32'h10 * (i % 3));
         wait_idle();
         logchk(5'((4 + i) % 20), 32'h210, 32'h7f0);
      end
      rdchk(`DST_REG_LOG_COUNT, 32'd20, 32'h1f);
      results();
   end
endmodule

/* tb/dst_seq_props.sv */
// Port checks for the self-test sequencer
`timescale 1ns/10ps
`include "dst_defs.vh"
module dst_seq_props #(
   parameter HEADS = 4'd8
) (
   input wire clk,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [3:0] work_op,
   input wire [15:0] work_arg,
   input wire work_start,
   input wire work_done,
   input wire work_fail
);
   logic [3:0] last_op_q;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) last_op_q <= 4'h0;
      else if (work_start) last_op_q <= work_op;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_APB_ZERO_WAIT: assert property (psel |-> pready && !pslverr)
      else $error("apb answer not zero wait");
   AST_START_PULSE: assert property (work_start |=> !work_start)
      else $error("work start longer than one cycle");
   AST_SEEK_COUNT: assert property (work_start && work_op == `DST_OP_SEEK |-> work_arg < 16'd256)
      else $error("seek index out of range");
   AST_HEAD_COUNT: assert property (work_start && (work_op == `DST_OP_WRC_HEAD || work_op == `DST_OP_HEAD_RW)
      |-> work_arg < HEADS) else $error("head index out of range");
   AST_RAND_COUNT: assert property (work_start && work_op == `DST_OP_RAND_VFY |-> work_arg < 16'd4000)
      else $error("random verify index out of range");
   AST_SEQ_SPAN: assert property (work_start && (work_op == `DST_OP_SEQ_FIRST || work_op == `DST_OP_SEQ_LAST)
      |-> work_arg == (work_op == `DST_OP_SEQ_FIRST ? 16'd300 : 16'd100)) else $error("short verify span wrong");
   AST_HEAD_ORDER: assert property (work_start && work_op == `DST_OP_WRC_HEAD
      |-> last_op_q == `DST_OP_SPIN || last_op_q == `DST_OP_WRC_HEAD) else $error("head test out of order");
   AST_SEEK_ORDER: assert property (work_start && work_op == `DST_OP_SEEK
      |-> last_op_q == `DST_OP_WRC_HEAD || last_op_q == `DST_OP_SEEK) else $error("seek test out of order");
   AST_RAND_ORDER: assert property (work_start && work_op == `DST_OP_RAND_VFY
      |-> last_op_q == `DST_OP_HEAD_RW || last_op_q == `DST_OP_RAND_VFY) else $error("random verify out of order");
   cover property (work_start && work_op == `DST_OP_SEQ_LAST);
   cover property (work_done && work_fail);
   cover property (psel && penable && pwrite && paddr == `DST_REG_CMD);
endmodule

bind dst_seq dst_seq_props #(.HEADS(HEADS)) u_props (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .work_op(work_op), .work_arg(work_arg), .work_start(work_start), .work_done(work_done), .work_fail(work_fail));
